// ==== hdl/abmd_pkg.sv ====
// package: shared constants and carrier types for the adapter bus memory decoder
package abmd_pkg;
   // ----------------------------------------------------------------
   // address boundaries (word-aligned 16-bit byte addresses)
   // ----------------------------------------------------------------
   localparam logic [15:0] ABMD_REG_LO = 16'h0000;
   localparam logic [15:0] ABMD_REG_HI = 16'h0ffe;
   localparam logic [15:0] ABMD_PHREG_LO = 16'h0100;
   localparam logic [15:0] ABMD_PHREG_HI = 16'h012e;
   localparam logic [15:0] ABMD_XRAM_LO = 16'h1000;
   localparam logic [15:0] ABMD_XRAM_HI = 16'h3ffe;
   localparam logic [15:0] ABMD_SRAM_LO = 16'h4000;
   localparam logic [15:0] ABMD_SRAM_HI = 16'h7ffe;
   localparam logic [15:0] ABMD_EPROM_LO = 16'h8000;
   localparam logic [15:0] ABMD_EPROM_HI = 16'hfffe;
   localparam logic [15:0] ABMD_ROM_LO = 16'hc000;
   localparam logic [15:0] ABMD_ROM_HI = 16'hfffe;
   localparam logic [15:0] ABMD_DBUF_HI = 16'hbffe;
   localparam int ABMD_MSB = 15;
   localparam int ABMD_EPROM_AW = 14;
   localparam logic [1:0] ABMD_EPROM_WAITS = 2'h1;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef enum logic {ABMD_CFG_EPROM, ABMD_CFG_DRAM} abmd_cfg_e;

   typedef struct packed {
      logic [15:0] addr;
      logic instr_data_status;
      logic addr_phase_bit15;
      logic is_cp;
   } abmd_cycle_s;

   typedef struct packed {
      logic eprom;
      logic sram;
      logic xram;
      logic dram_instr;
      logic dram_data;
      logic handler;
   } abmd_sel_s;
endpackage : abmd_pkg

// ==== hdl/abmd_range.sv ====
// range comparator: one address window test
`timescale 1ns/10ps
`default_nettype none
module abmd_range #(
   parameter logic [15:0] LO = 16'h0000,
   parameter logic [15:0] HI = 16'hfffe
) (
   input wire logic [15:0] addr,
   output logic hit
);
   // bit 0 is ignored: the bus moves whole words only
   assign hit = (addr[15:1] >= LO[15:1]) && (addr[15:1] <= HI[15:1]);
endmodule : abmd_range
`default_nettype wire

// ==== hdl/abmd_decode.sv ====
// adapter bus memory decoder: address latch, chip selects, wait state, parity fetch
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// (RL1) eprom configuration: program eproms enabled for 8000 to fffe.
// (RL2) eprom configuration: mandatory static ram buffer enabled for 4000 to 7ffe.
// (RL3) optional extra ram enabled for 1000 to 3ffe in eprom configuration.
// (RL4) no external memory enabled for 0000 to 0ffe.
// (RL5) optionally one wait state on program eprom accesses.
// (RL6) static ram completes with zero wait states and carries parity.
// (RL7) eprom configuration: handler select inactive for 8000 to fffe.
// (RL8) handler select active for 0100 to 012e.
// (RL9) simple build drives handler select from latched address msb.
// (RL10) parity eprom drives odd byte parity onto high and low parity lines.
// (RL11) debug firmware image holds eprom top address high, code from c000.
// (RL12) dram configuration: instruction/data status is an extra address bit.
// (RL13) host keeps rom disable low after reset so handler rom is mapped.
// (RL14) hardware reset traps processor to handler rom; firmware must be reloaded.
// (RL15) mac-only dram build keeps handler rom, dram 1000 to bffe buffers.
// (RL16) dma masters drive instruction/data status low, so data space.
// (RL17) latch bus bit 15 at address phase; low selects instruction-only map.
// (RL18) bit 15 high gives the normal partitioned instruction/data decode.
// (RL19) dram: handler select for 0000-0ffe and c000-fffe while rom enabled.
// (RL20) rom disable set: handler rom off, dram covers c000 to fffe.
// (RL21) at most one select per cycle, none for uncovered addresses. Simple build selects handler for 0000 to 7ffe, together with the rams.
module abmd_decode
   import abmd_pkg::*;
#(
   parameter abmd_cfg_e CFG = ABMD_CFG_EPROM,
   parameter bit EXTRA_RAM = 1'b0,
   parameter bit EPROM_WAIT = 1'b0,
   parameter bit SIMPLE_HANDLER = 1'b0,
   parameter bit DEBUG_IMAGE = 1'b0,
   parameter bit MAC_ONLY = 1'b0
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic addr_strobe,
   input wire logic data_strobe,
   input wire abmd_pkg::abmd_cycle_s cycle_in,
   input wire logic handler_rom_disable,
   input wire logic hardware_reset_n,
   input wire logic [1:0] parity_rom_data,
   output abmd_pkg::abmd_sel_s sel_q,
   output logic handler_select_n,
   output logic ready,
   output logic [ABMD_EPROM_AW-1:0] eprom_addr_q,
   output logic parity_high_line,
   output logic parity_low_line,
   output logic parity_oe,
   output logic parity_check_strap,
   output logic rom_trap_pending_q
);
   import abmd_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic dis_s1_q, dis_s2_q, hrst_s1_q, hrst_s2_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dis_s1_q <= 1'b0;
         dis_s2_q <= 1'b0;
         hrst_s1_q <= 1'b1;
         hrst_s2_q <= 1'b1;
      end else begin
         dis_s1_q <= handler_rom_disable;
         dis_s2_q <= dis_s1_q;
         hrst_s1_q <= hardware_reset_n;
         hrst_s2_q <= hrst_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // address latch
   // ----------------------------------------------------------------
   // strobes come from the bus master on mclk, so they are used directly
   abmd_cycle_s lat_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lat_q <= '0;
      end else if (addr_strobe) begin
         lat_q <= cycle_in; // see (RL17)
      end
   end

   wire [15:0] a = lat_q.addr;
   // dma masters never drive the status high; forcing it keeps a glitch out of
   // instruction space
   wire instr_sp = lat_q.instr_data_status & lat_q.is_cp; // see (RL16)
   wire dl_map = ~lat_q.addr_phase_bit15; // see (RL17)

   // ----------------------------------------------------------------
   // window comparators
   // ----------------------------------------------------------------
   logic h_reg, h_phreg, h_xram, h_sram, h_eprom, h_rom, h_dbuf;

   abmd_range #(.LO(ABMD_REG_LO), .HI(ABMD_REG_HI)) u_reg (.addr(a), .hit(h_reg));
   abmd_range #(.LO(ABMD_PHREG_LO), .HI(ABMD_PHREG_HI)) u_phreg (.addr(a), .hit(h_phreg));
   abmd_range #(.LO(ABMD_XRAM_LO), .HI(ABMD_XRAM_HI)) u_xram (.addr(a), .hit(h_xram));
   abmd_range #(.LO(ABMD_SRAM_LO), .HI(ABMD_SRAM_HI)) u_sram (.addr(a), .hit(h_sram));
   abmd_range #(.LO(ABMD_EPROM_LO), .HI(ABMD_EPROM_HI)) u_eprom (.addr(a), .hit(h_eprom));
   abmd_range #(.LO(ABMD_ROM_LO), .HI(ABMD_ROM_HI)) u_rom (.addr(a), .hit(h_rom));
   abmd_range #(.LO(ABMD_XRAM_LO), .HI(ABMD_DBUF_HI)) u_dbuf (.addr(a), .hit(h_dbuf));

   // ----------------------------------------------------------------
   // rom trap after hardware reset
   // ----------------------------------------------------------------
   // a hardware reset leaves dram contents stale; the rom stays mapped until
   // the host raises the disable again after reloading
   logic rom_trap_d;
   assign rom_trap_d = (~hrst_s2_q) | (rom_trap_pending_q & dis_s2_q); // see (RL14)

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rom_trap_pending_q <= 1'b1;
      end else begin
         rom_trap_pending_q <= rom_trap_d;
      end
   end

   // rom is mapped while disable is low or a trap is pending
   wire rom_on = ~dis_s2_q | rom_trap_pending_q | MAC_ONLY; // see (RL13) see (RL15) see (RL20)

   // ----------------------------------------------------------------
   // eprom configuration decode
   // ----------------------------------------------------------------
   wire e_eprom = h_eprom; // see (RL1)
   wire e_sram = h_sram; // see (RL2)
   wire e_xram = EXTRA_RAM & h_xram; // see (RL3)
   // registers and on-chip ram below 1000 never reach external memory
   wire e_hsel = SIMPLE_HANDLER ? ~a[ABMD_MSB] : h_phreg; // see (RL8) see (RL9)
   wire e_handler = e_hsel & ~h_eprom; // see (RL7)

   // ----------------------------------------------------------------
   // dram configuration decode
   // ----------------------------------------------------------------
   wire d_handler = h_reg | (h_rom & rom_on); // see (RL19)
   wire d_mem = ~d_handler & ~h_reg; // see (RL4) see (RL20)
   wire d_instr = d_mem & (dl_map | instr_sp); // see (RL12) see (RL17) see (RL18)
   wire d_data = d_mem & ~dl_map & ~instr_sp; // see (RL12) see (RL18)

   // ----------------------------------------------------------------
   // select register
   // ----------------------------------------------------------------
   abmd_sel_s sel_d;

   always_comb begin
      sel_d = '0;
      if (CFG == ABMD_CFG_EPROM) begin
         sel_d.eprom = e_eprom;
         sel_d.sram = e_sram;
         sel_d.xram = e_xram;
         sel_d.handler = e_handler;
      end else begin
         sel_d.dram_instr = d_instr;
         sel_d.dram_data = d_data;
         sel_d.handler = d_handler;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= '0;
      end else if (addr_strobe) begin
         sel_q <= '0;
      end else begin
         sel_q <= sel_d; // see (RL21)
      end
   end

   assign handler_select_n = ~sel_q.handler;

   // ----------------------------------------------------------------
   // eprom address and debug image
   // ----------------------------------------------------------------
   logic [ABMD_EPROM_AW-1:0] eprom_addr_d;

   always_comb begin
      eprom_addr_d = a[ABMD_EPROM_AW:1];
      if (DEBUG_IMAGE) begin
         eprom_addr_d[ABMD_EPROM_AW-1] = 1'b1; // see (RL11)
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         eprom_addr_q <= '0;
      end else begin
         eprom_addr_q <= eprom_addr_d;
      end
   end

   // ----------------------------------------------------------------
   // wait state
   // ----------------------------------------------------------------
   // slower eproms trade one cycle per fetch; ram never waits
   logic [1:0] wait_q, wait_d;
   wire wait_load = data_strobe & sel_q.eprom & EPROM_WAIT & (wait_q == 2'h0);

   always_comb begin
      wait_d = wait_q;
      if (addr_strobe) begin
         wait_d = 2'h0;
      end else if (wait_load) begin
         wait_d = ABMD_EPROM_WAITS; // see (RL5)
      end else if (wait_q == ABMD_EPROM_WAITS) begin
         wait_d = 2'h2;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 2'h0;
      end else begin
         wait_q <= wait_d;
      end
   end

   // ready low only in the one inserted cycle; the counter then parks until the next
   // address phase, so a data strobe held high cannot stall the bus a second time
   assign ready = ~wait_load; // see (RL5) see (RL6)

   // ----------------------------------------------------------------
   // parity lines
   // ----------------------------------------------------------------
   // the parity eprom only answers eprom reads; static ram parity is carried by
   // the ram itself on the same lines
   logic ph_q, pl_q, poe_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ph_q <= 1'b0;
         pl_q <= 1'b0;
         poe_q <= 1'b0;
      end else begin
         ph_q <= parity_rom_data[1]; // see (RL10)
         pl_q <= parity_rom_data[0]; // see (RL10)
         poe_q <= data_strobe & sel_q.eprom & (CFG == ABMD_CFG_EPROM);
      end
   end

   assign parity_high_line = ph_q;
   assign parity_low_line = pl_q;
   assign parity_oe = poe_q;
   // strap low enables parity checks; only safe when eproms hold the code
   assign parity_check_strap = ~((CFG == ABMD_CFG_EPROM) & ~MAC_ONLY);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // whole map: exclusivity and the register hole
   a_no_low_mem: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL4)
      (lat_q.addr <= ABMD_REG_HI && !addr_strobe) |=>
      !(sel_q.eprom | sel_q.sram | sel_q.xram | sel_q.dram_instr | sel_q.dram_data))
      else $error("external memory selected in register range");
   a_one_select: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL21)
      $onehot0(sel_q))
      else $error("more than one select active");
   a_reg_unmapped: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL21)
      (CFG == ABMD_CFG_EPROM && !SIMPLE_HANDLER && h_reg && !h_phreg && !addr_strobe)
      |=> sel_q == '0)
      else $error("select active for uncovered address");
   a_dram_no_static: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL21)
      (CFG == ABMD_CFG_DRAM) |-> !(sel_q.eprom | sel_q.sram | sel_q.xram))
      else $error("static memory selected in dram build");

   // eprom build windows, wait state and parity
   a_eprom_window: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL1)
      (CFG == ABMD_CFG_EPROM && h_eprom && !addr_strobe) |=> sel_q.eprom && handler_select_n)
      else $error("eprom window decode wrong");
   a_eprom_addr: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL1)
      1'b1 |=> eprom_addr_q[ABMD_EPROM_AW-2:0] == $past(lat_q.addr[ABMD_EPROM_AW-1:1]))
      else $error("eprom address not following latch");
   a_debug_top: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL11)
      (DEBUG_IMAGE == 1'b1) |=> eprom_addr_q[ABMD_EPROM_AW-1])
      else $error("debug image top address bit low");
   a_sram_window: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL2)
      (CFG == ABMD_CFG_EPROM && !addr_strobe) |=> sel_q.sram == $past(h_sram))
      else $error("sram window decode wrong");
   a_xram_window: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL3)
      (CFG == ABMD_CFG_EPROM && !addr_strobe) |=> sel_q.xram == (EXTRA_RAM && $past(h_xram)))
      else $error("extra ram window decode wrong");
   a_eprom_deselect: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL7)
      (CFG == ABMD_CFG_EPROM && sel_q.eprom) |-> handler_select_n)
      else $error("handler selected in eprom window");
   a_phreg_window: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL8)
      (h_phreg && !addr_strobe) |=> !handler_select_n)
      else $error("handler registers not selected");
   a_sram_nowait: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL6)
      (sel_q.sram || sel_q.dram_data) |-> ready)
      else $error("ram access stalled");
   a_eprom_wait: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL5)
      (!ready && !addr_strobe) |=> ready)
      else $error("more than one wait state");
   a_parity_pass: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL10)
      (CFG == ABMD_CFG_EPROM && data_strobe && sel_q.eprom) |=>
      parity_oe && {parity_high_line, parity_low_line} == $past(parity_rom_data))
      else $error("parity lines not driven from parity eprom");

   // dram build: instruction and data split, rom mapping
   a_instr_space: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL12)
      (CFG == ABMD_CFG_DRAM && d_mem && !dl_map && lat_q.instr_data_status && lat_q.is_cp
      && !addr_strobe) |=> sel_q.dram_instr)
      else $error("instruction fetch missed instruction space");
   a_data_space: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL18)
      (CFG == ABMD_CFG_DRAM && d_mem && !dl_map && !lat_q.instr_data_status && !addr_strobe)
      |=> sel_q.dram_data)
      else $error("data access missed data space");
   a_rom_reset: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL14)
      !hrst_s2_q |=> rom_trap_pending_q && rom_on)
      else $error("rom not restored after hardware reset");
   a_rom_trap_hold: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL14)
      (rom_trap_pending_q && dis_s2_q) |=> rom_trap_pending_q)
      else $error("rom trap released while disable held");
   a_handler_regs_dram: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL19)
      (CFG == ABMD_CFG_DRAM && h_reg && !addr_strobe) |=> !handler_select_n)
      else $error("handler registers not selected in dram build");
   a_rom_mapped: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL19)
      (CFG == ABMD_CFG_DRAM && h_rom && !dis_s2_q && !addr_strobe) |=> !handler_select_n)
      else $error("handler rom missing while disable low");
   a_mac_rom: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL15)
      (CFG == ABMD_CFG_DRAM && MAC_ONLY && h_rom && !addr_strobe) |=> !handler_select_n)
      else $error("handler rom unmapped in mac-only build");
   a_dram_buffer: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL15)
      (CFG == ABMD_CFG_DRAM && h_dbuf && !addr_strobe) |=> sel_q.dram_instr || sel_q.dram_data)
      else $error("dram buffer window not selected");
   a_rom_disable: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL20)
      (CFG == ABMD_CFG_DRAM && !MAC_ONLY && !rom_on && h_rom && !addr_strobe)
      |=> handler_select_n)
      else $error("handler rom active while disabled");
   a_dl_map: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL17)
      (CFG == ABMD_CFG_DRAM && dl_map && d_mem && !addr_strobe) |=> sel_q.dram_instr)
      else $error("download map missed instruction space");
   a_dma_data: assert property (@(posedge mclk) disable iff (!rst_n) // see (RL16)
      (CFG == ABMD_CFG_DRAM && !lat_q.is_cp && !dl_map && d_mem && !addr_strobe)
      |=> sel_q.dram_data)
      else $error("dma access left data space");

   c_eprom_fetch: cover property (@(posedge mclk) disable iff (!rst_n) sel_q.eprom ##1 ready);
   c_wait_state: cover property (@(posedge mclk) disable iff (!rst_n) !ready);
   c_dram_instr: cover property (@(posedge mclk) disable iff (!rst_n) sel_q.dram_instr);
   c_rom_off: cover property (@(posedge mclk) disable iff (!rst_n) !rom_trap_pending_q);
   c_trap_reset: cover property (@(posedge mclk) disable iff (!rst_n)
      !hrst_s2_q ##1 rom_trap_pending_q);
endmodule : abmd_decode
`default_nettype wire

// ==== testbench/abmd_parity_rom.sv ====
// partner model: parity eprom that feeds the byte parity lines of the decoder
`timescale 1ns/10ps
`default_nettype none
module abmd_parity_rom
   import abmd_pkg::*;
(
   input wire logic [ABMD_EPROM_AW-1:0] eprom_addr_q,
   input wire logic selected,
   output logic [1:0] parity_rom_data
);
   // ----------------------------------------------------------------
   // contents: one {high,low} parity pair per word, derived from the word address
   // ----------------------------------------------------------------
   logic [1:0] stored;
   assign stored = {eprom_addr_q[1] ^ eprom_addr_q[2], ~eprom_addr_q[0]};
   // deselected outputs float; show the inverse so stale data never passes
   assign parity_rom_data = selected ? stored : ~stored;
endmodule : abmd_parity_rom
`default_nettype wire

// ==== testbench/abmd_decode_bench.sv ====
// testbench: eprom and dram builds of the decoder driven by one bus master
`timescale 1ns/10ps
`default_nettype none
module abmd_decode_bench import abmd_pkg::*;;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic mclk, rst_n, addr_strobe, data_strobe, handler_rom_disable, hardware_reset_n;
   logic ready, parity_high_line, parity_low_line, parity_oe, strap_ep, strap_dr;
   logic hs_ep_n, hs_dr_n, trap_dr, rom_on, strap_mac;
   logic [1:0] parity_rom_data;
   logic [ABMD_EPROM_AW-1:0] eprom_addr_q, eprom_addr_dbg;
   abmd_cycle_s cyc_in;
   abmd_sel_s sel_ep, sel_dr, sel_mac;
   int n_fail, samples_checked;
   logic [15:0] addrs [15] = '{16'h0000, 16'h00fe, 16'h0100, 16'h012e, 16'h0130, 16'h0ffe,
      16'h1000, 16'h3ffe, 16'h4000, 16'h7ffe, 16'h8000, 16'h8006, 16'hbffe, 16'hc000, 16'hfffe};
   logic [2:0] modes [4] = '{3'h7, 3'h3, 3'h6, 3'h5}; // {instr_data, bit15, is_cp}

   // ----------------------------------------------------------------
   // designs under test and partner
   // ----------------------------------------------------------------
   abmd_decode #(.CFG(ABMD_CFG_EPROM), .EXTRA_RAM(1'b1), .EPROM_WAIT(1'b1)) dut (
      .mclk(mclk), .rst_n(rst_n), .addr_strobe(addr_strobe), .data_strobe(data_strobe),
      .cycle_in(cyc_in), .handler_rom_disable(handler_rom_disable),
      .hardware_reset_n(hardware_reset_n), .parity_rom_data(parity_rom_data),
      .sel_q(sel_ep), .handler_select_n(hs_ep_n), .ready(ready), .eprom_addr_q(eprom_addr_q),
      .parity_high_line(parity_high_line), .parity_low_line(parity_low_line),
      .parity_oe(parity_oe), .parity_check_strap(strap_ep), .rom_trap_pending_q());
   abmd_decode #(.CFG(ABMD_CFG_DRAM)) dut_dram (
      .mclk(mclk), .rst_n(rst_n), .addr_strobe(addr_strobe), .data_strobe(data_strobe),
      .cycle_in(cyc_in), .handler_rom_disable(handler_rom_disable),
      .hardware_reset_n(hardware_reset_n), .parity_rom_data(2'h0),
      .sel_q(sel_dr), .handler_select_n(hs_dr_n), .ready(), .eprom_addr_q(),
      .parity_high_line(), .parity_low_line(), .parity_oe(), .parity_check_strap(strap_dr),
      .rom_trap_pending_q(trap_dr));
   abmd_decode #(.CFG(ABMD_CFG_DRAM), .MAC_ONLY(1'b1)) dut_mac (
      .mclk(mclk), .rst_n(rst_n), .addr_strobe(addr_strobe), .data_strobe(data_strobe),
      .cycle_in(cyc_in), .handler_rom_disable(handler_rom_disable),
      .hardware_reset_n(hardware_reset_n), .parity_rom_data(2'h0),
      .sel_q(sel_mac), .handler_select_n(), .ready(), .eprom_addr_q(),
      .parity_high_line(), .parity_low_line(), .parity_oe(), .parity_check_strap(strap_mac),
      .rom_trap_pending_q());
   abmd_decode #(.CFG(ABMD_CFG_EPROM), .DEBUG_IMAGE(1'b1)) dut_dbg (
      .mclk(mclk), .rst_n(rst_n), .addr_strobe(addr_strobe), .data_strobe(data_strobe),
      .cycle_in(cyc_in), .handler_rom_disable(handler_rom_disable),
      .hardware_reset_n(hardware_reset_n), .parity_rom_data(2'h0),
      .sel_q(), .handler_select_n(), .ready(), .eprom_addr_q(eprom_addr_dbg),
      .parity_high_line(), .parity_low_line(), .parity_oe(), .parity_check_strap(),
      .rom_trap_pending_q());
   abmd_parity_rom rom (.eprom_addr_q(eprom_addr_q), .selected(sel_ep.eprom),
      .parity_rom_data(parity_rom_data));

   // ----------------------------------------------------------------
   // expected maps
   // ----------------------------------------------------------------
   function automatic abmd_sel_s exp_ep(input logic [15:0] a);
      abmd_sel_s s;
      s = '0;
      if (a >= ABMD_EPROM_LO) s.eprom = 1'b1;
      else if (a >= ABMD_SRAM_LO) s.sram = 1'b1;
      else if (a >= ABMD_XRAM_LO) s.xram = 1'b1;
      else if (a >= ABMD_PHREG_LO && a <= ABMD_PHREG_HI) s.handler = 1'b1;
      return s;
   endfunction : exp_ep

   function automatic abmd_sel_s exp_dr(input logic [15:0] a, input logic [2:0] m,
                                        input logic ron);
      abmd_sel_s s;
      s = '0;
      if (a <= ABMD_REG_HI || (ron && a >= ABMD_ROM_LO)) s.handler = 1'b1;
      else if (!m[1] || (m[2] && m[0])) s.dram_instr = 1'b1;
      else s.dram_data = 1'b1;
      return s;
   endfunction : exp_dr

   // ----------------------------------------------------------------
   // compare, bus cycle and verdict tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic cyc(input logic [15:0] a, input logic [2:0] m);
      abmd_sel_s ee, ed;
      ee = exp_ep(a);
      ed = exp_dr(a, m, rom_on);
      cyc_in = '{addr: a, instr_data_status: m[2], addr_phase_bit15: m[1], is_cp: m[0]};
      addr_strobe = 1'b1;
      @(negedge mclk);
      addr_strobe = 1'b0;
      repeat (2) @(negedge mclk);
      chk("sel_eprom_build", {10'h0, ee}, {10'h0, sel_ep});
      chk("sel_dram_build", {10'h0, ed}, {10'h0, sel_dr});
      chk("sel_mac_build", {10'h0, exp_dr(a, m, 1'b1)}, {10'h0, sel_mac});
      chk("handler_select_n_eprom", {15'h0, ~ee.handler}, {15'h0, hs_ep_n});
      chk("handler_select_n_dram", {15'h0, ~ed.handler}, {15'h0, hs_dr_n});
      data_strobe = 1'b1;
      #1;
      chk("ready_first", {15'h0, ~ee.eprom}, {15'h0, ready});
      @(negedge mclk);
      chk("ready_second", 16'h1, {15'h0, ready});
      chk("parity_oe", {15'h0, ee.eprom}, {15'h0, parity_oe});
      if (ee.eprom) begin
         chk("eprom_addr", {2'h0, a[14:1]}, {2'h0, eprom_addr_q});
         chk("eprom_addr_debug", {2'h0, 1'b1, a[13:1]}, {2'h0, eprom_addr_dbg});
         chk("parity", {14'h0, a[2] ^ a[3], ~a[1]},
             {14'h0, parity_high_line, parity_low_line});
      end
      data_strobe = 1'b0;
      @(negedge mclk);
   endtask : cyc

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // clock, watchdog and test sequence
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // about 76 bus cycles of five clocks each expected; this leaves a wide margin
   initial begin
      #500_000;
      n_fail++;
      results();
   end

   initial begin
      n_fail = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      addr_strobe = 1'b0;
      data_strobe = 1'b0;
      cyc_in = '0;
      handler_rom_disable = 1'b0;
      hardware_reset_n = 1'b1;
      rom_on = 1'b1;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      chk("strap_eprom", 16'h0, {15'h0, strap_ep});
      chk("strap_dram", 16'h1, {15'h0, strap_dr});
      chk("strap_mac", 16'h1, {15'h0, strap_mac});
      foreach (addrs[i]) foreach (modes[j]) cyc(addrs[i], modes[j]);
      handler_rom_disable = 1'b1;
      repeat (5) @(negedge mclk);
      rom_on = 1'b0;
      for (int i = 12; i < 15; i++) foreach (modes[j]) cyc(addrs[i], modes[j]);
      hardware_reset_n = 1'b0;
      repeat (4) @(negedge mclk);
      hardware_reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      rom_on = 1'b1;
      chk("trap_pending", 16'h1, {15'h0, trap_dr});
      foreach (modes[j]) cyc(16'hc000, modes[j]);
      results();
   end
endmodule : abmd_decode_bench
`default_nettype wire
